/* rtl/ccb_user_end.sv */
// User end: credit accounting and gating of non-posted requests
`timescale 1ns/1ps
//
// What this block does
// - Core reserves 64 completion header credits
// - Core reserves 7936 or 15872 data bytes
// - Issue request only when space suffices
// - Read length never exceeds max request size
// - Max request code 0..5 doubles from 128
// - Unread max request size means 128 bytes
// - Reserve headers for worst-case completion count
// - First completion ends at request end/boundary
// - Last completion ends at start plus length
// - Middle completions are whole boundary multiples
// - Two boundary status bits, one per function
// - Boundary bit 0 is 64B, 1 is 128B
// - Unread boundary status means 64 bytes
// - Header credits equal boundary blocks spanned
// - Merged completions welcome, not required
// - Data credit is 16 bytes per unit
// - Check both totals, then add needs
module ccb_user_end
  import ccb_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  ccb_if.user                        bus,
  input  wire logic                  use_cfg_i,
  input  wire logic                  func_sel_i,
  input  wire logic                  req_valid_i,
  input  wire logic [CCB_ADDR_W-1:0] req_addr_i,
  input  wire logic [CCB_LEN_W-1:0]  req_len_i,
  output logic                       req_ready_o,
  output logic                       req_too_long_o,
  output logic [CCB_HCNT_W-1:0]      cplh_pend_o,
  output logic [CCB_DCNT_W-1:0]      cpld_pend_o
);
  typedef enum logic [0:0]
  {
    CCB_GATE_OPEN = 1'b0,
    CCB_GATE_SENT = 1'b1
  } ccb_gate_e;

  logic [CCB_LEN_W-1:0]  lim_bytes;
  logic [3:0]            fn_shift  [CCB_N_FUNC];
  logic [CCB_HCNT_W-1:0] fn_need_h [CCB_N_FUNC];
  logic [CCB_DCNT_W-1:0] fn_need_d [CCB_N_FUNC];
  logic [CCB_HCNT_W-1:0] need_h;
  logic [CCB_DCNT_W-1:0] need_d;
  logic [CCB_HCNT_W:0]   sum_h;
  logic [CCB_DCNT_W:0]   sum_d;
  logic                  fits;
  logic                  len_ok;
  logic                  issue;
  logic [CCB_HCNT_W-1:0] next_h;
  logic [CCB_DCNT_W-1:0] next_d;
  ccb_gate_e             gate;
  ccb_gate_e             next_gate;

  //////////////////////////////////////////////////////////////////////////////
  // Decoders
  // Boundary status bit to its address shift
  function automatic logic [3:0] rcb_shift_of(input logic rcb_bit);
    rcb_shift_of = rcb_bit ? 4'(CCB_RCB_SHIFT_128) : 4'(CCB_RCB_SHIFT_64);
  endfunction

  // Worst case: partial first block, whole middle blocks, partial last
  function automatic logic [CCB_HCNT_W-1:0] blocks_spanned
  (
    input logic [CCB_ADDR_W-1:0] addr,
    input logic [CCB_LEN_W-1:0]  len,
    input logic [3:0]            shift
  );
    logic [CCB_LEN_W:0] mask;
    logic [CCB_LEN_W:0] span;
    mask           = ((CCB_LEN_W+1)'(1) << shift) - (CCB_LEN_W+1)'(1);
    span           = ((CCB_LEN_W+1)'(addr) & mask) + (CCB_LEN_W+1)'(len) + mask;
    blocks_spanned = CCB_HCNT_W'(span >> shift);
  endfunction

  // Data credits held by a number of boundary blocks
  function automatic logic [CCB_DCNT_W-1:0] block_credits
  (
    input logic [CCB_HCNT_W-1:0] blocks,
    input logic [3:0]            shift
  );
    block_credits = CCB_DCNT_W'(blocks) << (shift - 4'(CCB_CREDIT_SHIFT));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Need per physical function, picked by the request's function
  for (genvar f = 0; f < CCB_N_FUNC; f++)
  begin : g_func
    assign fn_shift[f]  = use_cfg_i ? rcb_shift_of(bus.rcb_status[f])
                                    : 4'(CCB_RCB_SHIFT_64);
    assign fn_need_h[f] = blocks_spanned(req_addr_i, req_len_i, fn_shift[f]);
    assign fn_need_d[f] = block_credits(fn_need_h[f], fn_shift[f]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Limits in force and budget check
  always_comb
  begin
    lim_bytes = (use_cfg_i && bus.max_req_valid) ? bus.max_req_bytes
              : (CCB_LEN_W'(1) << CCB_MRS_BASE_SHIFT);
    need_h = fn_need_h[func_sel_i];
    need_d = fn_need_d[func_sel_i];
    sum_h  = (CCB_HCNT_W+1)'(cplh_pend_o) + (CCB_HCNT_W+1)'(need_h);
    sum_d  = (CCB_DCNT_W+1)'(cpld_pend_o) + (CCB_DCNT_W+1)'(need_d);
    fits   = (sum_h <= (CCB_HCNT_W+1)'(bus.cplh_total))
          && (sum_d <= (CCB_DCNT_W+1)'(bus.cpld_total));
    len_ok = (req_len_i != '0) && (req_len_i <= lim_bytes);
    issue  = req_valid_i && len_ok && fits && (gate == CCB_GATE_OPEN);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request gate: one issue, then one quiet cycle
  always_comb
  begin
    case (gate)
      CCB_GATE_OPEN: next_gate = issue ? CCB_GATE_SENT : CCB_GATE_OPEN;
      CCB_GATE_SENT: next_gate = CCB_GATE_OPEN;
      default:       next_gate = CCB_GATE_OPEN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gate <= CCB_GATE_OPEN;
    end
    else
    begin
      gate <= next_gate;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pending counters: add on issue, subtract on return
  always_comb
  begin
    next_h = cplh_pend_o;
    next_d = cpld_pend_o;
    if (issue)
    begin
      next_h = next_h + need_h;
      next_d = next_d + need_d;
    end
    if (bus.cpl_ret)
    begin
      next_h = next_h - bus.cpl_ret_h;
      next_d = next_d - bus.cpl_ret_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cplh_pend_o <= '0;
    end
    else
    begin
      cplh_pend_o <= next_h;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpld_pend_o <= '0;
    end
    else
    begin
      cpld_pend_o <= next_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus.np_req <= 1'b0;
    end
    else
    begin
      bus.np_req <= issue;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_ready_o <= 1'b0;
    end
    else
    begin
      req_ready_o <= issue;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_too_long_o <= 1'b0;
    end
    else
    begin
      req_too_long_o <= req_valid_i && !len_ok;
    end
  end
endmodule

/* rtl/ccb_pkg.sv */
// Shared constants for the completion credit budget ends
package ccb_pkg;
  localparam int unsigned CCB_CPLH_TOTAL      = 64;
  localparam int unsigned CCB_CPLD_BYTES_GOOD = 7936;
  localparam int unsigned CCB_CPLD_BYTES_HIGH = 15872;
  localparam int unsigned CCB_CREDIT_BYTES    = 16;
  localparam int unsigned CCB_CREDIT_SHIFT    = 4;
  localparam int unsigned CCB_HCNT_W          = 8;
  localparam int unsigned CCB_DCNT_W          = 11;
  localparam int unsigned CCB_LEN_W           = 13;
  localparam int unsigned CCB_ADDR_W          = 12;
  localparam logic [2:0]  CCB_MRS_128         = 3'h0;
  localparam logic [2:0]  CCB_MRS_4096        = 3'h5;
  localparam int unsigned CCB_MRS_BASE_SHIFT  = 7;
  localparam int unsigned CCB_RCB_SHIFT_64    = 6;
  localparam int unsigned CCB_RCB_SHIFT_128   = 7;
  localparam logic [1:0]  CCB_RCB_DEFAULT     = 2'h0;
  localparam logic [2:0]  CCB_MRS_DEFAULT     = 3'h0;
  localparam int unsigned CCB_MRS_MSB         = 14;
  localparam int unsigned CCB_MRS_LSB         = 12;
  localparam int unsigned CCB_N_FUNC          = 2;
endpackage

/* rtl/ccb_if.sv */
// Interface joining the core-side budget status and the user-side requester
`timescale 1ns/1ps
interface ccb_if;
  import ccb_pkg::*;
  logic [CCB_HCNT_W-1:0] cplh_total;
  logic [CCB_DCNT_W-1:0] cpld_total;
  logic [2:0]            max_req_code;
  logic [CCB_LEN_W-1:0]  max_req_bytes;
  logic                  max_req_valid;
  logic [1:0]            rcb_status;
  logic                  np_req;
  logic                  cpl_ret;
  logic [CCB_HCNT_W-1:0] cpl_ret_h;
  logic [CCB_DCNT_W-1:0] cpl_ret_d;
  modport core (output cplh_total, cpld_total, max_req_code, max_req_bytes, max_req_valid,
                rcb_status, cpl_ret, cpl_ret_h, cpl_ret_d, input np_req);
  modport user (input cplh_total, cpld_total, max_req_code, max_req_bytes, max_req_valid,
                rcb_status, cpl_ret, cpl_ret_h, cpl_ret_d, output np_req);
endinterface

/* rtl/ccb_core_end.sv */
// Core end: reserved completion space, request size and boundary status
`timescale 1ns/1ps
module ccb_core_end
  import ccb_pkg::*;
#(
  parameter bit HIGH_PERF = 1'b1
)(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  ccb_if.core                        bus,
  input  wire logic [15:0]           dev_ctrl_i,
  input  wire logic [1:0]            rcb_cfg_i,
  input  wire logic                  cpl_ret_i,
  input  wire logic [CCB_HCNT_W-1:0] cpl_ret_h_i,
  input  wire logic [CCB_DCNT_W-1:0] cpl_ret_d_i,
  output logic                       np_seen_o
);
  localparam int unsigned CPLD_BYTES = HIGH_PERF ? CCB_CPLD_BYTES_HIGH : CCB_CPLD_BYTES_GOOD;

  function automatic logic [CCB_LEN_W-1:0] mrs_bytes(input logic [2:0] code);
    mrs_bytes = CCB_LEN_W'(1) << (CCB_MRS_BASE_SHIFT + 32'(code));
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus.cplh_total <= '0;
      bus.cpld_total <= '0;
    end
    else
    begin
      bus.cplh_total <= CCB_HCNT_W'(CCB_CPLH_TOTAL);
      bus.cpld_total <= CCB_DCNT_W'(CPLD_BYTES >> CCB_CREDIT_SHIFT);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus.max_req_code  <= CCB_MRS_DEFAULT;
      bus.max_req_bytes <= mrs_bytes(CCB_MRS_DEFAULT);
      bus.max_req_valid <= 1'b0;
    end
    else
    begin
      bus.max_req_code  <= dev_ctrl_i[CCB_MRS_MSB:CCB_MRS_LSB];
      bus.max_req_valid <= dev_ctrl_i[CCB_MRS_MSB:CCB_MRS_LSB] <= CCB_MRS_4096;
      bus.max_req_bytes <= (dev_ctrl_i[CCB_MRS_MSB:CCB_MRS_LSB] <= CCB_MRS_4096) ?
                           mrs_bytes(dev_ctrl_i[CCB_MRS_MSB:CCB_MRS_LSB])
                           : mrs_bytes(CCB_MRS_128);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus.rcb_status <= CCB_RCB_DEFAULT;
    else
      bus.rcb_status <= rcb_cfg_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus.cpl_ret   <= 1'b0;
      bus.cpl_ret_h <= '0;
      bus.cpl_ret_d <= '0;
      np_seen_o     <= 1'b0;
    end
    else
    begin
      bus.cpl_ret   <= cpl_ret_i;
      bus.cpl_ret_h <= cpl_ret_h_i;
      bus.cpl_ret_d <= cpl_ret_d_i;
      np_seen_o     <= bus.np_req;
    end
  end
endmodule

/* sim/ccb_chk.sv */
// Checker on the signals between the two credit budget ends
`timescale 1ns/1ps
module ccb_chk
  import ccb_pkg::*;
#(
  parameter bit HIGH_PERF = 1'b1
)(
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic [CCB_HCNT_W-1:0] cplh_total,
  input wire logic [CCB_DCNT_W-1:0] cpld_total,
  input wire logic [2:0]            max_req_code,
  input wire logic [CCB_LEN_W-1:0]  max_req_bytes,
  input wire logic                  max_req_valid,
  input wire logic                  np_req,
  input wire logic                  cpl_ret
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  a_hdr_total: assert property (!$past(rst_i) |-> cplh_total == 8'h40)
    else $error("header total wrong");
  a_data_total: assert property (!$past(rst_i) |->
    cpld_total == (HIGH_PERF ? 11'h3E0 : 11'h1F0)) else $error("data total wrong");
  a_tot_const: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    $stable(cplh_total) && $stable(cpld_total)) else $error("totals moved");
  a_mrs_bytes: assert property (max_req_valid |->
    max_req_bytes == (13'h0080 << max_req_code)) else $error("size decode wrong");
  a_mrs_valid: assert property (!$past(rst_i) |->
    max_req_valid == (max_req_code < 3'h6)) else $error("size valid wrong");
  a_rsvd_bytes: assert property (!max_req_valid |-> max_req_bytes == 13'h0080)
    else $error("reserved size not 128");
  a_np_pulse: assert property (np_req |=> !np_req) else $error("requests too close");
  a_np_room: assert property (np_req |-> cplh_total != 8'h00 && cpld_total != 11'h000)
    else $error("request with no space");
  c_issue: cover property (np_req);
  c_return: cover property (cpl_ret);
  c_rsvd: cover property (!max_req_valid);
  c_pair: cover property (np_req ##2 np_req);
endmodule

/* sim/completion_credit_budget_test.sv */
// Self-checking bench joining both credit budget ends
`timescale 1ns/1ps
module completion_credit_budget_test
  import ccb_pkg::*;
;
  logic        clk_i, rst_i, use_cfg, fsel, rv, cr, rdy, tl, seen;
  logic [1:0]  rcb;
  logic [15:0] dc;
  logic [11:0] ad;
  logic [12:0] ln;
  logic [7:0]  crh, ph;
  logic [10:0] crd, pd;
  int          n_fail, n_tests, cyc, eh, ed;
  ccb_if bus();
  ccb_core_end i_ccb_core_end (.clk_i, .rst_i, .bus(bus), .dev_ctrl_i(dc), .rcb_cfg_i(rcb),
    .cpl_ret_i(cr), .cpl_ret_h_i(crh), .cpl_ret_d_i(crd), .np_seen_o(seen));
  ccb_user_end i_ccb_user_end (.clk_i, .rst_i, .bus(bus), .use_cfg_i(use_cfg),
    .func_sel_i(fsel), .req_valid_i(rv), .req_addr_i(ad), .req_len_i(ln), .req_ready_o(rdy),
    .req_too_long_o(tl), .cplh_pend_o(ph), .cpld_pend_o(pd));
  ccb_chk i_ccb_chk (.clk_i, .rst_i, .cplh_total(bus.cplh_total),
    .cpld_total(bus.cpld_total), .max_req_code(bus.max_req_code),
    .max_req_bytes(bus.max_req_bytes), .max_req_valid(bus.max_req_valid),
    .np_req(bus.np_req), .cpl_ret(bus.cpl_ret));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Issue one request, expect worst-case header and data need added
  task issue(input logic [11:0] a, input logic [12:0] l, input int r);
    int h;
    h = (a % r + l + r - 1) / r;
    @(posedge clk_i);
    rv <= 1'b1; ad <= a; ln <= l;
    repeat (40)
    begin
      @(negedge clk_i);
      if (rdy === 1'b1) break;
    end
    eh += h;
    ed += h * r / 16;
    chk(rdy, 1);
    chk(ph, eh);
    chk(pd, ed);
    @(posedge clk_i);
    rv <= 1'b0;
    @(negedge clk_i);
    chk(seen, 1);
  endtask
  task ret(input int h, input int d);
    @(posedge clk_i);
    cr <= 1'b1; crh <= 8'(h); crd <= 11'(d);
    @(posedge clk_i);
    cr <= 1'b0;
    eh -= h;
    ed -= d;
  endtask
  initial
  begin
    clk_i = 0; rst_i = 1; use_cfg = 0; fsel = 0; rv = 0; cr = 0; rcb = 0; dc = 0;
    ad = 0; ln = 0; crh = 0; crd = 0; n_fail = 0; n_tests = 0; cyc = 0; eh = 0; ed = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk(bus.cplh_total, 64);
    chk(bus.cpld_total, 992);
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clk_i);
      dc <= 16'(c) << 12;
      repeat (3) @(negedge clk_i);
      chk(bus.max_req_bytes, c < 6 ? 128 << c : 128);
    end
    issue(12'h07C, 13'h0008, 64);
    issue(12'h040, 13'h0080, 64);
    @(posedge clk_i);
    rv <= 1'b1; ln <= 13'h0081;
    repeat (3) @(negedge clk_i);
    chk(tl, 1);
    chk(rdy, 0);
    @(posedge clk_i);
    rv <= 1'b0;
    ret(4, 16);
    repeat (3) @(negedge clk_i);
    chk(ph, eh);
    chk(pd, ed);
    @(posedge clk_i);
    use_cfg <= 1'b1; rcb <= 2'b10; fsel <= 1'b1; dc <= 16'h5000;
    issue(12'h07C, 13'h0008, 128);
    @(posedge clk_i);
    fsel <= 1'b0;
    issue(12'h07C, 13'h0008, 64);
    ret(4, 24);
    issue(12'h000, 13'h1000, 64);
    @(posedge clk_i);
    rv <= 1'b1; ad <= 12'h000; ln <= 13'h0004;
    repeat (6) @(negedge clk_i);
    chk(rdy, 0);
    ret(64, 256);
    issue(12'h000, 13'h0004, 64);
    wrap_up();
  end
endmodule
